// >>> test_ts_counter.sv
// Purpose: self-checking bench for ts_counter
// Assumes: TB4_CYC cut to 20 cycles for run time
// Notes: queued notes hold {overflow_led, count_value}
`timescale 1ns/1ps
`default_nettype none
module test_ts_counter;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] src = 2'h0;
    logic lvl = 1'b0;
    logic [3:0] pos = 4'h0;
    logic mr = 1'b0;
    logic note_due = 1'b0;
    logic te, tdn, td, led, run;
    logic [15:0] cnt;
    logic [16:0] q[$];
    logic [31:0] seed = 32'h9;
    int per[5] = '{1, 10, 100, 1000, 20};
    int n_errors = 0;
    int n_tests = 0;
    int gap, i, k, n;
    always #50 clk_sys = !clk_sys;
    ts_trig_model u_src (.clk_sys(clk_sys), .rst_n(rst_n), .src(src), .lvl(lvl),
        .trig_event(te), .trig_direct_n(tdn), .trig_direct(td));
    ts_counter #(.TB4_CYC(20)) DUT (.clk_sys(clk_sys), .rst_n(rst_n), .trig_event(te),
        .trig_direct_n(tdn), .trig_direct(td), .trig_src_sel(src), .switch_pos(pos),
        .manual_reset(mr), .count_value(cnt), .overflow_led(led), .counting(run));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        if (n_errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic cyc(input int c);
        repeat (c) @(posedge clk_sys);
    endtask : cyc
    // source only moves under manual reset, so no stray edge reaches the sync
    task automatic set(input logic [3:0] p, input logic l, input logic m);
        @(posedge clk_sys);
        pos <= p;
        lvl <= l;
        mr <= m;
        if (m) src <= 2'(rnd() % 4);
    endtask : set
    task automatic clr(input logic [3:0] p);
        set(p, 1'b0, 1'b1);
        // hold the clear until a trigger still in the sync has drained
        cyc(3);
        set(p, 1'b0, 1'b0);
    endtask : clr
    task automatic pulse(input int h, input int l);
        @(posedge clk_sys);
        lvl <= 1'b1;
        cyc(h);
        lvl <= 1'b0;
        cyc(l);
    endtask : pulse
    task automatic note(input logic [16:0] v);
        @(posedge clk_sys);
        q.push_back(v);
        note_due <= 1'b1;
        @(posedge clk_sys);
        note_due <= 1'b0;
    endtask : note
    task automatic run_is(input logic v);
        @(negedge clk_sys);
        check({31'h0, run}, {31'h0, v});
    endtask : run_is
    // period between two count changes, after aligning on one
    task automatic gap_of(input logic [3:0] p, input logic l, input int exp);
        logic [15:0] c0;
        set(p, l, 1'b0);
        cyc(4);
        @(negedge clk_sys);
        c0 = cnt;
        for (k = 0; k < 3000 && cnt === c0; k++) @(negedge clk_sys);
        c0 = cnt;
        gap = 0;
        for (k = 0; k < 3000 && cnt === c0; k++) begin
            @(negedge clk_sys);
            gap++;
        end
        check(gap, exp);
        check({16'h0, 16'(cnt - c0)}, 32'h1);
    endtask : gap_of
    always @(negedge clk_sys) begin
        if (note_due === 1'b1 && q.size() > 0) begin
            check({15'h0, led, cnt}, {15'h0, q.pop_front()});
        end
    end
    initial begin
        repeat (90000) @(posedge clk_sys);
        n_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        clr(4'h0);
        for (i = 0; i < 5; i++) gap_of(4'(i), 1'b0, per[i]);
        gap_of(4'h5, 1'b1, 1);
        gap_of(4'h9, 1'b1, 20);
        set(4'h0, 1'b1, 1'b0);
        cyc(6);
        note(17'h00000);
        clr(4'h5);
        cyc(10);
        note(17'h00000);
        clr(4'hF);
        n = 2 + int'(rnd() % 4);
        repeat (n) pulse(4, 4);
        note({1'b0, 16'(n)});
        set(4'hA, 1'b0, 1'b0);
        pulse(20, 4);
        note(17'h00000);
        run_is(1'b0);
        cyc(20);
        note(17'h00000);
        pulse(4, 4);
        cyc(20);
        run_is(1'b1);
        pulse(4, 4);
        run_is(1'b0);
        pulse(4, 4);
        cyc(10);
        set(4'hA, 1'b0, 1'b1);
        note(17'h00000);
        run_is(1'b0);
        clr(4'h0);
        for (i = 0; i < 70000 && cnt !== 16'hFFFF; i++) @(negedge clk_sys);
        note(17'h10000);
        set(4'h0, 1'b0, 1'b1);
        note(17'h00000);
        set(4'h0, 1'b0, 1'b0);
        cyc(4);
        tally_and_finish();
    end
endmodule : test_ts_counter
`default_nettype wire

// >>> ts_counter.sv
// Purpose: 16-bit time stamp counter behind an emulator analysis port
// Assumes: inputs synchronous or slow; manual_reset is a clean level
// Notes: selector picks time base and counting behaviour together
//
// Operation
// - Direct trigger input that is active low, for low-going interrupt lines.
// - Second direct trigger input, active high, skipping monitor delay.
// - Trigger comes from the event monitor or one of two direct inputs.
// - Manual reset clears the counter to zero.
// - Overflow indicator lights past 65,535 and stays lit until manual reset.
// - Counter wraps to zero on overflow and keeps counting.
// - Selector sets time base .1 uS to 1 mS and counting behaviour.
// - Positions 0-4: trigger high resets, otherwise count ticks freely.
// - Positions 0-4: without triggers the counter free-runs and may overflow.
// - Positions 5-9: count ticks only while trigger is high, else hold.
// - Positions A-E: trigger longer than 1.6 uS resets the counter.
// - Positions A-E: after that, short triggers alternately start and stop.
// - Positions A-E: manual reset halts and clears the counter.
// - Position F: count trigger rising edges, ignore time base.
`timescale 1ns/1ps
`default_nettype none
`include "ts_defs.svh"

module ts_counter #(
    parameter int TB4_CYC = `TS_CYC(`TS_TB4_NS),
    parameter int LONG_CYC = `TS_LONG_PULSE_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic trig_event,
    input wire logic trig_direct_n,
    input wire logic trig_direct,
    input wire logic [1:0] trig_src_sel,
    input wire logic [3:0] switch_pos,
    input wire logic manual_reset,
    output logic [15:0] count_value,
    output logic overflow_led,
    output logic counting
);

    // ----------------------------------------
    // trigger source
    // ----------------------------------------
    logic trig_raw;

    // unused code falls back to the monitor pulse, the default source
    always_comb begin
        unique case (trig_src_sel)
            `TS_SRC_DIRECT_N: trig_raw = ~trig_direct_n;
            `TS_SRC_DIRECT: trig_raw = trig_direct;
            default: trig_raw = trig_event;
        endcase
    end

    logic trig_level;
    logic trig_rise;
    logic trig_long;
    logic trig_short_fall;

    ts_trig_sync #(
        .LONG_CYC(LONG_CYC)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .raw(trig_raw),
        .level(trig_level),
        .rise(trig_rise),
        .long_hit(trig_long),
        .short_fall(trig_short_fall)
    );

    // ----------------------------------------
    // selector decode
    // ----------------------------------------
    ts_pkg::mode_e mode;
    logic [2:0] tb_sel;

    always_comb begin
        if (switch_pos == `TS_POS_EDGE) begin
            mode = ts_pkg::MODE_EDGE_COUNT;
            tb_sel = 3'h0;
        end else if (switch_pos >= `TS_POS_TOGGLE_LO) begin
            mode = ts_pkg::MODE_TOGGLE;
            tb_sel = 3'(switch_pos - `TS_POS_TOGGLE_LO);
        end else if (switch_pos >= `TS_POS_GATE_LO) begin
            mode = ts_pkg::MODE_GATED;
            tb_sel = 3'(switch_pos - `TS_POS_GATE_LO);
        end else begin
            mode = ts_pkg::MODE_RESET_ON_TRIG;
            tb_sel = 3'(switch_pos);
        end
    end

    // ----------------------------------------
    // time base
    // ----------------------------------------
    logic tick;

    ts_prescaler #(
        .P4(TB4_CYC)
    ) u_presc (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .sel(tb_sel),
        .tick(tick)
    );

    // ----------------------------------------
    // count state
    // ----------------------------------------
    ts_pkg::count_t count_r, count_nxt;
    logic run_r, run_nxt;
    logic ovf_r, ovf_nxt;
    logic inc;
    logic clear;

    always_comb begin
        inc = 1'b0;
        clear = 1'b0;
        run_nxt = run_r;
        unique case (mode)
            ts_pkg::MODE_RESET_ON_TRIG: begin
                run_nxt = 1'b1;
                if (trig_level) begin
                    clear = 1'b1;
                end else begin
                    inc = tick;
                end
            end
            ts_pkg::MODE_GATED: begin
                run_nxt = trig_level;
                inc = tick && trig_level;
            end
            ts_pkg::MODE_TOGGLE: begin
                if (trig_long) begin
                    clear = 1'b1;
                    run_nxt = 1'b0;
                end else if (trig_short_fall) begin
                    run_nxt = ~run_r;
                end
                inc = tick && run_r;
            end
            ts_pkg::MODE_EDGE_COUNT: begin
                run_nxt = 1'b1;
                inc = trig_rise;
            end
        endcase
        // manual reset overrides every mode
        if (manual_reset) begin
            clear = 1'b1;
            inc = 1'b0;
            if (mode == ts_pkg::MODE_TOGGLE) begin
                run_nxt = 1'b0;
            end
        end
    end

    // wrap is plain unsigned rollover, no saturation
    always_comb begin
        count_nxt = count_r;
        ovf_nxt = ovf_r;
        if (manual_reset) begin
            // clearing the lamp here, a wrap in the same cycle is blocked
            ovf_nxt = 1'b0;
        end
        if (clear) begin
            count_nxt = `TS_COUNT_ZERO;
        end else if (inc) begin
            count_nxt = count_r + 16'h0001;
            if (count_r == `TS_COUNT_MAX) begin
                ovf_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= `TS_COUNT_ZERO;
            run_r <= 1'b0;
            ovf_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            run_r <= run_nxt;
            ovf_r <= ovf_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign count_value = count_r;
    assign overflow_led = ovf_r;
    assign counting = run_r;

endmodule : ts_counter
`default_nettype wire

// >>> ts_counter_asserts.sv
// Purpose: port checker for ts_counter
// Assumes: trig_src_sel code 3 acts as the monitor source
// Notes: windows padded for the two-stage trigger sync
`timescale 1ns/1ps
`default_nettype none
module ts_counter_asserts #(
    parameter int TB4_CYC = 20,
    parameter int LONG_CYC = 16
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic trig_event,
    input wire logic trig_direct_n,
    input wire logic trig_direct,
    input wire logic [1:0] trig_src_sel,
    input wire logic [3:0] switch_pos,
    input wire logic manual_reset,
    input wire logic [15:0] count_value,
    input wire logic overflow_led,
    input wire logic counting
);
    logic trg;
    logic tsel;
    logic tog;
    logic gate;
    logic f_ok;
    logic [5:0] hi_r;
    logic [5:0] hi_nxt;
    assign trg = (trig_src_sel == 2'h1) ? !trig_direct_n :
        (trig_src_sel == 2'h2) ? trig_direct : trig_event;
    assign tsel = switch_pos >= 4'hA && switch_pos <= 4'hE;
    assign tog = tsel && !manual_reset;
    assign gate = switch_pos >= 4'h5 && switch_pos <= 4'h9 && !manual_reset;
    assign f_ok = switch_pos == 4'hF && !manual_reset;
    // saturates so a stuck trigger cannot wrap back into the window
    always_comb begin
        hi_nxt = (tog && trg) ? hi_r + ((hi_r == 6'h3F) ? 6'h00 : 6'h01) : 6'h00;
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hi_r <= 6'h00;
        end else begin
            hi_r <= hi_nxt;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    clear_zero_a: assert property (manual_reset |=> count_value == 16'h0000)
        else $error("count not cleared by manual reset");
    led_hold_a: assert property (overflow_led && !manual_reset |=> overflow_led)
        else $error("overflow led dropped");
    wrap_zero_a: assert property ($rose(overflow_led) |->
        count_value == 16'h0000 && $past(count_value) == 16'hFFFF)
        else $error("overflow led without wrap");
    step_one_a: assert property (count_value != $past(count_value) |->
        count_value == $past(count_value) + 16'h0001 || count_value == 16'h0000)
        else $error("count jumped");
    trig_zero_a: assert property ((switch_pos < 4'h5 && trg)[*4] |=>
        count_value == 16'h0000)
        else $error("high trigger did not zero count");
    gate_hold_a: assert property ((gate && !trg)[*4] |=> $stable(count_value))
        else $error("count moved with gate low");
    edge_inc_a: assert property ((f_ok && !trg)[*4] ##1 (f_ok && trg)[*4] |=>
        count_value == $past(count_value, 5) + 16'h0001)
        else $error("rising trigger not counted once");
    long_clear_a: assert property (hi_r == LONG_CYC + 4 |->
        count_value == 16'h0000 && !counting)
        else $error("long trigger did not clear");
    halt_clear_a: assert property (tsel && manual_reset |=>
        count_value == 16'h0000 && !counting)
        else $error("manual reset did not halt");
    stop_hold_a: assert property ((tog && !counting)[*2] |->
        $stable(count_value) || count_value == 16'h0000)
        else $error("stopped count moved");
endmodule : ts_counter_asserts
bind ts_counter ts_counter_asserts #(.TB4_CYC(TB4_CYC), .LONG_CYC(LONG_CYC)) u_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .trig_event(trig_event),
    .trig_direct_n(trig_direct_n), .trig_direct(trig_direct), .trig_src_sel(trig_src_sel),
    .switch_pos(switch_pos), .manual_reset(manual_reset), .count_value(count_value),
    .overflow_led(overflow_led), .counting(counting));
`default_nettype wire

// >>> ts_defs.svh
// Purpose: shared constants for the trace time stamp counter
// Assumes: clk_sys runs at 10 MHz
// Notes: times are kept in ns; cycle counts derive from them
`ifndef TS_DEFS_SVH
`define TS_DEFS_SVH

// ----------------------------------------
// clock and time bases
// ----------------------------------------
`define TS_CLK_PERIOD_NS 100
`define TS_TB0_NS 100
`define TS_TB1_NS 1000
`define TS_TB2_NS 10000
`define TS_TB3_NS 100000
`define TS_TB4_NS 1000000
// least times round up to whole cycles
`define TS_CYC(ns) ((((ns) + `TS_CLK_PERIOD_NS - 1) / `TS_CLK_PERIOD_NS))

// ----------------------------------------
// trigger pulse width
// ----------------------------------------
`define TS_LONG_PULSE_NS 1600
// pulses longer than this many cycles count as long
`define TS_LONG_PULSE_CYC (`TS_LONG_PULSE_NS / `TS_CLK_PERIOD_NS)

// ----------------------------------------
// selector positions
// ----------------------------------------
`define TS_POS_GATE_LO 4'h5
`define TS_POS_TOGGLE_LO 4'hA
`define TS_POS_EDGE 4'hF
`define TS_BASES_PER_GROUP 4'h5

// ----------------------------------------
// trigger source codes
// ----------------------------------------
`define TS_SRC_MONITOR 2'h0
`define TS_SRC_DIRECT_N 2'h1
`define TS_SRC_DIRECT 2'h2

// ----------------------------------------
// counter values
// ----------------------------------------
`define TS_COUNT_ZERO 16'h0000
`define TS_COUNT_MAX 16'hFFFF

`endif

// >>> ts_pkg.sv
// Purpose: types for the trace time stamp counter
// Assumes: nothing beyond the shared header
// Notes: counting behaviours picked by the selector
package ts_pkg;

    typedef enum logic [1:0] {
        MODE_RESET_ON_TRIG,
        MODE_GATED,
        MODE_TOGGLE,
        MODE_EDGE_COUNT
    } mode_e;

    typedef logic [15:0] count_t;

endpackage : ts_pkg

// >>> ts_prescaler.sv
// Purpose: time base tick generator
// Assumes: sel holds 0 to 4
// Notes: restarts its count whenever sel changes
`timescale 1ns/1ps
`default_nettype none
`include "ts_defs.svh"

module ts_prescaler #(
    parameter int W = 14,
    parameter int P0 = `TS_CYC(`TS_TB0_NS),
    parameter int P1 = `TS_CYC(`TS_TB1_NS),
    parameter int P2 = `TS_CYC(`TS_TB2_NS),
    parameter int P3 = `TS_CYC(`TS_TB3_NS),
    parameter int P4 = `TS_CYC(`TS_TB4_NS)
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [2:0] sel,
    output logic tick
);

    localparam logic [W-1:0] LAST0 = W'(P0 - 1);
    localparam logic [W-1:0] LAST1 = W'(P1 - 1);
    localparam logic [W-1:0] LAST2 = W'(P2 - 1);
    localparam logic [W-1:0] LAST3 = W'(P3 - 1);
    localparam logic [W-1:0] LAST4 = W'(P4 - 1);
    localparam logic [W-1:0] ONE = W'(1);

    logic [W-1:0] cnt_r, cnt_nxt;
    logic [2:0] sel_r, sel_nxt;
    logic tick_r, tick_nxt;
    logic [W-1:0] last;

    // ----------------------------------------
    // divider
    // ----------------------------------------
    always_comb begin
        unique case (sel)
            3'h0: last = LAST0;
            3'h1: last = LAST1;
            3'h2: last = LAST2;
            3'h3: last = LAST3;
            default: last = LAST4;
        endcase
        sel_nxt = sel;
        tick_nxt = 1'b0;
        if (sel != sel_r) begin
            cnt_nxt = '0;
        end else if (cnt_r >= last) begin
            cnt_nxt = '0;
            tick_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + ONE;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            sel_r <= 3'h0;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            sel_r <= sel_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;

endmodule : ts_prescaler
`default_nettype wire

// >>> ts_trig_model.sv
// Purpose: trigger sources seen by ts_counter
// Assumes: lvl is the wanted trigger, active high
// Notes: unselected lines toggle so a wrong source mux shows up
`timescale 1ns/1ps
`default_nettype none
module ts_trig_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [1:0] src,
    input wire logic lvl,
    output logic trig_event,
    output logic trig_direct_n,
    output logic trig_direct
);
    logic noise_r;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            noise_r <= 1'b0;
        end else begin
            noise_r <= !noise_r;
        end
    end
    assign trig_event = (src == 2'h0 || src == 2'h3) ? lvl : noise_r;
    assign trig_direct_n = (src == 2'h1) ? !lvl : noise_r;
    assign trig_direct = (src == 2'h2) ? lvl : noise_r;
endmodule : ts_trig_model
`default_nettype wire

// >>> ts_trig_sync.sv
// Purpose: trigger synchroniser with edge and width detection
// Assumes: raw may be asynchronous to clk_sys
// Notes: all outputs derive from the second stage onward
`timescale 1ns/1ps
`default_nettype none
`include "ts_defs.svh"

module ts_trig_sync #(
    parameter int LONG_CYC = `TS_LONG_PULSE_CYC,
    parameter int WW = 6
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic raw,
    output logic level,
    output logic rise,
    output logic long_hit,
    output logic short_fall
);

    localparam logic [WW-1:0] LONG_W = WW'(LONG_CYC);
    localparam logic [WW-1:0] SAT_W = WW'(LONG_CYC + 1);
    localparam logic [WW-1:0] ONE = WW'(1);

    logic meta_r, sync_r, prev_r;
    logic [WW-1:0] width_r, width_nxt;

    // ----------------------------------------
    // synchroniser, first stage read only by second
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= raw;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // ----------------------------------------
    // pulse width, saturates just past the long limit
    // ----------------------------------------
    always_comb begin
        if (!sync_r) begin
            width_nxt = '0;
        end else if (width_r < SAT_W) begin
            width_nxt = width_r + ONE;
        end else begin
            width_nxt = width_r;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            width_r <= '0;
        end else begin
            width_r <= width_nxt;
        end
    end

    assign level = sync_r;
    assign rise = sync_r & ~prev_r;
    // fires in the first high cycle beyond the long limit
    assign long_hit = sync_r && (width_r == LONG_W);
    assign short_fall = !sync_r && prev_r && (width_r <= LONG_W);

endmodule : ts_trig_sync
`default_nettype wire
